/* shared/rpf_pkg.sv */
// Shared constants and types for the recovery and programmable frequency control block
package rpf_pkg;
    // ================================================================
    // Control byte offsets on the byte register port
    localparam logic [7:0] RPF_OFF_RECOV_N   = 8'h0B; // Recovery N byte
    localparam logic [7:0] RPF_OFF_RECOV_SM  = 8'h0C; // Recovery select and recovery M
    localparam logic [7:0] RPF_OFF_CPU_N     = 8'h0D; // CPU N byte
    localparam logic [7:0] RPF_OFF_CPU_EM    = 8'h0E; // Programmable enable and CPU M
    localparam logic [7:0] RPF_OFF_FTEST     = 8'h0F; // Factory test byte
    localparam logic [7:0] RPF_OFF_SPARE_A   = 8'h10; // Spare, reads zero
    localparam logic [7:0] RPF_OFF_SPARE_B   = 8'h11; // Spare, reads zero
    // ================================================================
    // Field positions and widths
    localparam int RPF_SEL_BIT   = 7;              // Select / enable bit in bytes 12 and 14
    localparam int RPF_N_W       = 8;              // N divider width
    localparam int RPF_M_W       = 7;              // M divider width
    localparam int RPF_FS_W      = 5;              // Strap / select field width
    localparam int RPF_FTEST_W   = 2;              // Factory test bits in byte 15
    // ================================================================
    // Reset values
    localparam logic [7:0] RPF_RST_BYTE  = 8'h00; // Bytes 11 to 14
    localparam logic [1:0] RPF_RST_FTEST = 2'h3;  // Factory test bits come up as ones
    // ================================================================
    // Strap settle count: cycles after reset release before the strap capture
    localparam logic [1:0] RPF_STRAP_SETTLE = 2'h3;
    // ================================================================
    // Frequency selection handed to the synthesizer core
    typedef struct packed {
        logic                use_dividers; // N/M pair drives the CPU clock
        logic [RPF_N_W-1:0]  div_n;        // N divider
        logic [RPF_M_W-1:0]  div_m;        // M divider
        logic [RPF_FS_W-1:0] ratio_sel;    // Ratio / gear select
    } rpf_freq_cfg_t;
    // Recovery lock state
    typedef enum logic [0:0] {
        RPF_ST_NORMAL = 1'b0,
        RPF_ST_LOCKED = 1'b1
    } rpf_state_t;
endpackage

/* logic/rpf_sync2.sv */
// Two-flop synchroniser for strap pins
`timescale 1ns/1ps
`default_nettype none
module rpf_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_q;

    // ================================================================
    // Synchroniser chain
    // Both stages register; no logic between them to keep MTBF up
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else if (ce_in) begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* logic/rpf_freq_ctrl.sv */
// Recovery and programmable frequency select control bytes
// Function
// - One bit picks the recovery frequency source
// - Zero means straps, one means recovery dividers
// - Watchdog timeout switches to recovery frequency automatically
// - Recovery frequency uses recovery N and M
// - Override bit picks straps or programmed select outside recovery; locked recovery uses latched straps
// - Programmable enable bit resets to disabled
// - Enabled: CPU frequency from CPU N and M
// - Writing CPU M starts the frequency load
// - Locked recovery mode ignores frequency byte writes
// - Clearing watchdog enable unlocks frequency programming
// - Disabled: straps or select per override bit
// - Enabled watchdog starts after frequency change
`timescale 1ns/1ps
`default_nettype none
module rpf_freq_ctrl
    import rpf_pkg::*;
(
    input  wire logic                   core_clk_in,         // 40 MHz reference clock
    input  wire logic                   rst_in,              // Asynchronous, active high
    input  wire logic                   ce_in,               // Freezes all state while low
    input  wire logic                   reg_wr_en_in,        // Byte write strobe
    input  wire logic                   reg_rd_en_in,        // Byte read strobe
    input  wire logic [7:0]             reg_addr_in,         // Byte offset
    input  wire logic [7:0]             reg_wdata_in,        // Write data
    output logic      [7:0]             reg_rdata_out,       // Read data, one cycle after read
    input  wire logic [RPF_FS_W-1:0]    strap_pins_in,       // Raw strap pins
    input  wire logic                   strap_override_in,   // Programmed override bit
    input  wire logic [RPF_FS_W-1:0]    prog_select_in,      // Programmed select field
    input  wire logic                   watchdog_enable_in,  // Watchdog enable bit
    input  wire logic                   watchdog_timeout_in, // Timeout pulse from watchdog
    output rpf_pkg::rpf_freq_cfg_t      freq_cfg_out,        // Frequency selection to core
    output logic                        freq_load_out,       // Frequency change pulse
    output logic                        watchdog_start_out,  // Countdown start pulse
    output logic                        recovery_locked_out, // Recovery mode flag
    output logic [RPF_FS_W-1:0]         latched_strap_select_out // Latched straps
);
    import rpf_pkg::*;

    // ================================================================
    // Strap capture
    logic [RPF_FS_W-1:0] strap_sync;                 // Synchronised strap pins
    logic [1:0]          settle_q, settle_d;         // Settle counter
    logic [RPF_FS_W-1:0] latched_strap_select_q, latched_strap_select_d;

    rpf_sync2 #(.WIDTH(RPF_FS_W)) u_strap_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .ce_in       (ce_in),
        .async_in    (strap_pins_in),
        .sync_out    (strap_sync)
    );

    // Capture once after the chain has filled; later pin motion is ignored
    always_comb begin
        settle_d               = settle_q;
        latched_strap_select_d = latched_strap_select_q;
        if (settle_q != RPF_STRAP_SETTLE) begin
            settle_d = settle_q + 2'h1;
            if (settle_d == RPF_STRAP_SETTLE) begin
                latched_strap_select_d = strap_sync;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            settle_q               <= 2'h0;
            latched_strap_select_q <= '0;
        end else if (ce_in) begin
            settle_q               <= settle_d;
            latched_strap_select_q <= latched_strap_select_d;
        end
    end

    // ================================================================
    // Control bytes
    logic [RPF_N_W-1:0]     recovery_divider_n_q, recovery_divider_n_d;
    logic                   recovery_source_select_q, recovery_source_select_d;
    logic [RPF_M_W-1:0]     recovery_divider_m_q, recovery_divider_m_d;
    logic [RPF_N_W-1:0]     cpu_divider_n_q, cpu_divider_n_d;
    logic                   prog_freq_enable_q, prog_freq_enable_d;
    logic [RPF_M_W-1:0]     cpu_divider_m_q, cpu_divider_m_d;
    logic [RPF_FTEST_W-1:0] ftest_q, ftest_d;
    logic [7:0]             rdata_q, rdata_d;
    logic                   wr_ok;                   // Write accepted this cycle
    logic                   cpu_m_wr;                // CPU M byte written

    rpf_state_t state_q, state_d;

    // Frequency bytes are refused while locked in recovery mode
    assign wr_ok    = reg_wr_en_in && (state_q == RPF_ST_NORMAL);
    assign cpu_m_wr = wr_ok && (reg_addr_in == RPF_OFF_CPU_EM);

    // Next register values; each field holds until its own byte is written
    always_comb begin
        recovery_divider_n_d     = recovery_divider_n_q;
        recovery_source_select_d = recovery_source_select_q;
        recovery_divider_m_d     = recovery_divider_m_q;
        cpu_divider_n_d          = cpu_divider_n_q;
        prog_freq_enable_d       = prog_freq_enable_q;
        cpu_divider_m_d          = cpu_divider_m_q;
        ftest_d                  = ftest_q;
        rdata_d                  = rdata_q;
        if (wr_ok) begin
            unique case (reg_addr_in)
                RPF_OFF_RECOV_N: begin
                    recovery_divider_n_d = reg_wdata_in;
                end
                RPF_OFF_RECOV_SM: begin
                    recovery_source_select_d = reg_wdata_in[RPF_SEL_BIT];
                    recovery_divider_m_d     = reg_wdata_in[RPF_M_W-1:0];
                end
                RPF_OFF_CPU_N: begin
                    cpu_divider_n_d = reg_wdata_in;
                end
                RPF_OFF_CPU_EM: begin
                    prog_freq_enable_d = reg_wdata_in[RPF_SEL_BIT];
                    cpu_divider_m_d    = reg_wdata_in[RPF_M_W-1:0];
                end
                RPF_OFF_FTEST: begin
                    // Host is expected to keep these ones; stored as written
                    ftest_d = reg_wdata_in[RPF_FTEST_W-1:0];
                end
                // Spare bytes and unmapped offsets drop the write
                default: begin
                end
            endcase
        end
        if (reg_rd_en_in) begin
            unique case (reg_addr_in)
                RPF_OFF_RECOV_N:  rdata_d = recovery_divider_n_q;
                RPF_OFF_RECOV_SM: rdata_d = {recovery_source_select_q, recovery_divider_m_q};
                RPF_OFF_CPU_N:    rdata_d = cpu_divider_n_q;
                RPF_OFF_CPU_EM:   rdata_d = {prog_freq_enable_q, cpu_divider_m_q};
                RPF_OFF_FTEST:    rdata_d = {6'h00, ftest_q};
                // Spare bytes and unmapped offsets read zero
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    // Power-on values: all fields zero, test bits ones
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            recovery_divider_n_q     <= RPF_RST_BYTE;
            recovery_source_select_q <= 1'b0;
            recovery_divider_m_q     <= '0;
            cpu_divider_n_q          <= RPF_RST_BYTE;
            prog_freq_enable_q       <= 1'b0;
            cpu_divider_m_q          <= '0;
            ftest_q                  <= RPF_RST_FTEST;
            rdata_q                  <= RPF_RST_BYTE;
        end else if (ce_in) begin
            recovery_divider_n_q     <= recovery_divider_n_d;
            recovery_source_select_q <= recovery_source_select_d;
            recovery_divider_m_q     <= recovery_divider_m_d;
            cpu_divider_n_q          <= cpu_divider_n_d;
            prog_freq_enable_q       <= prog_freq_enable_d;
            cpu_divider_m_q          <= cpu_divider_m_d;
            ftest_q                  <= ftest_d;
            rdata_q                  <= rdata_d;
        end
    end

    // ================================================================
    // Recovery lock and frequency selection
    rpf_freq_cfg_t cfg_q, cfg_d;
    logic          load_q, load_d;
    logic          wd_start_q, wd_start_d;
    logic          enter_lock;

    // Timeout only locks while the watchdog is enabled
    assign enter_lock = (state_q == RPF_ST_NORMAL) && watchdog_timeout_in && watchdog_enable_in;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            RPF_ST_NORMAL: begin
                if (enter_lock) begin
                    state_d = RPF_ST_LOCKED;
                end
            end
            RPF_ST_LOCKED: begin
                if (!watchdog_enable_in) begin
                    state_d = RPF_ST_NORMAL;
                end
            end
        endcase
        // Selection follows the next state and next register values; a register write
        // reaches the core on the same edge that commits it, taken from the write data
        if (state_d == RPF_ST_LOCKED) begin
            if (recovery_source_select_d) begin
                cfg_d.use_dividers = 1'b1;
                cfg_d.div_n        = recovery_divider_n_d;
                cfg_d.div_m        = recovery_divider_m_d;
            end else begin
                cfg_d.use_dividers = 1'b0;
                cfg_d.div_n        = cpu_divider_n_d;
                cfg_d.div_m        = cpu_divider_m_d;
            end
            cfg_d.ratio_sel = latched_strap_select_d;
        end else begin
            cfg_d.use_dividers = prog_freq_enable_d;
            cfg_d.div_n        = cpu_divider_n_d;
            cfg_d.div_m        = cpu_divider_m_d;
            // Ratio always follows the override bit; dividers only set CPU rate
            cfg_d.ratio_sel    = strap_override_in ? prog_select_in
                                                   : latched_strap_select_d;
        end
        // Load on CPU M write or on the switch into recovery
        load_d     = cpu_m_wr || enter_lock;
        wd_start_d = cpu_m_wr && watchdog_enable_in;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q    <= RPF_ST_NORMAL;
            cfg_q      <= '0;
            load_q     <= 1'b0;
            wd_start_q <= 1'b0;
        end else if (ce_in) begin
            state_q    <= state_d;
            cfg_q      <= cfg_d;
            load_q     <= load_d;
            wd_start_q <= wd_start_d;
        end
    end

    assign reg_rdata_out            = rdata_q;
    assign freq_cfg_out             = cfg_q;
    assign freq_load_out            = load_q;
    assign watchdog_start_out       = wd_start_q;
    assign recovery_locked_out      = (state_q == RPF_ST_LOCKED);
    assign latched_strap_select_out = latched_strap_select_q;

    // ================================================================
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_timeout;
        ce_in && !recovery_locked_out && watchdog_timeout_in && watchdog_enable_in;
    endsequence
    sequence s_m_write;
        ce_in && !recovery_locked_out && reg_wr_en_in && reg_addr_in == RPF_OFF_CPU_EM;
    endsequence

    timeout_lock_a: assert property (s_timeout |=> recovery_locked_out && freq_load_out)
        else $error("timeout did not lock recovery");
    recov_div_sel_a: assert property (s_timeout ##0 recovery_source_select_q
        |=> freq_cfg_out.use_dividers && freq_cfg_out.div_n == recovery_divider_n_q)
        else $error("recovery dividers not applied");
    recov_strap_a: assert property (recovery_locked_out && !recovery_source_select_q
        |-> !freq_cfg_out.use_dividers && freq_cfg_out.ratio_sel == latched_strap_select_q)
        else $error("recovery strap source wrong");
    locked_ignore_a: assert property (recovery_locked_out && ce_in && reg_wr_en_in
        |=> $stable(cpu_divider_m_q) && $stable(prog_freq_enable_q))
        else $error("write accepted while locked");
    unlock_a: assert property (recovery_locked_out && ce_in && !watchdog_enable_in
        |=> !recovery_locked_out)
        else $error("lock not released");
    m_load_a: assert property (s_m_write |=> freq_load_out ##1 (!freq_load_out || !$past(ce_in)))
        else $error("CPU M write gave no load pulse");
    wd_start_a: assert property (s_m_write ##0 watchdog_enable_in |=> watchdog_start_out)
        else $error("watchdog start missing");
    prog_cfg_a: assert property (!recovery_locked_out && prog_freq_enable_q
        |-> freq_cfg_out.use_dividers && freq_cfg_out.div_m == cpu_divider_m_q)
        else $error("programmed dividers not used");
    ratio_sel_a: assert property (!recovery_locked_out && !prog_freq_enable_q && ce_in ##1
        !recovery_locked_out && $past(strap_override_in)
        |-> freq_cfg_out.ratio_sel == $past(prog_select_in))
        else $error("override select not applied");
    spare_read_a: assert property (ce_in && reg_rd_en_in && reg_addr_in >= RPF_OFF_SPARE_A
        |=> reg_rdata_out == 8'h00)
        else $error("spare byte read nonzero");
endmodule
`default_nettype wire

/* verif/rpf_host_model.sv */
// Management bus host model driving the control byte port and the loose control bits
`timescale 1ns/1ps
`default_nettype none
module rpf_host_model (
    input  wire logic                     core_clk_in,         // Reference clock
    output logic                          reg_wr_en_out,       // Byte write strobe
    output logic                          reg_rd_en_out,       // Byte read strobe
    output logic [7:0]                    reg_addr_out,        // Byte offset
    output logic [7:0]                    reg_wdata_out,       // Write data
    input  wire logic [7:0]               reg_rdata_in,        // Read data from the device
    output logic                          watchdog_enable_out, // Watchdog enable bit
    output logic                          strap_override_out,  // Override bit
    output logic [rpf_pkg::RPF_FS_W-1:0]  prog_select_out      // Programmed select field
);
    import rpf_pkg::*;
    // ================================================================
    // Idle values at time zero
    initial begin
        reg_wr_en_out       = 1'b0;
        reg_rd_en_out       = 1'b0;
        reg_addr_out        = 8'h00;
        reg_wdata_out       = 8'h00;
        watchdog_enable_out = 1'b0;
        strap_override_out  = 1'b0;
        prog_select_out     = '0;
    end
    // ================================================================
    // Byte write; released lines show the inverse so stale data never looks valid
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        begin
            v = d;
            // Firmware always writes ones into the two factory test bits
            if (a == RPF_OFF_FTEST) begin
                v[1:0] = 2'h3;
            end
            @(posedge core_clk_in);
            reg_wr_en_out <= 1'b1;
            reg_addr_out  <= a;
            reg_wdata_out <= v;
            @(posedge core_clk_in);
            reg_wr_en_out <= 1'b0;
            reg_addr_out  <= ~a;
            reg_wdata_out <= ~v;
        end
    endtask
    // ================================================================
    // Byte read; data is taken once the taking edge has settled
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        reg_rd_en_out <= 1'b1;
        reg_addr_out  <= a;
        @(posedge core_clk_in);
        reg_rd_en_out <= 1'b0;
        reg_addr_out  <= ~a;
        #1;
        d = reg_rdata_in;
    endtask
    // ================================================================
    // Loose bits; clearing the watchdog enable is how the host leaves recovery
    task automatic set_bits(input logic wd, input logic ov, input logic [RPF_FS_W-1:0] sel);
        @(posedge core_clk_in);
        watchdog_enable_out <= wd;
        strap_override_out  <= ov;
        prog_select_out     <= sel;
    endtask
endmodule
`default_nettype wire

/* verif/rpf_freq_ctrl_tb.sv */
// Self-checking testbench for the frequency select control block
`timescale 1ns/1ps
`default_nettype none
module rpf_freq_ctrl_tb;
    import rpf_pkg::*;
    // ================================================================
    // Design connections
    logic                core_clk_in, rst_in, ce_in, wr_en, rd_en, watchdog_enable, ov, tmo;
    logic [7:0]          addr, wdata, rdata, a, d;
    logic [RPF_FS_W-1:0] straps, psel, latched;
    rpf_freq_cfg_t       cfg;                 // Frequency selection seen
    logic                load, wstart, locked;
    logic [7:0]          m_rn, m_rsm, m_cn, m_cem; // Mirror of the control bytes
    logic [31:0]         rnd;
    int                  seed, miscompares, n_checks;
    // ================================================================
    rpf_freq_ctrl i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .strap_pins_in(straps), .strap_override_in(ov), .prog_select_in(psel),
        .watchdog_enable_in(watchdog_enable), .watchdog_timeout_in(tmo), .freq_cfg_out(cfg),
        .freq_load_out(load), .watchdog_start_out(wstart), .recovery_locked_out(locked),
        .latched_strap_select_out(latched));
    rpf_host_model i_host (.core_clk_in(core_clk_in), .reg_wr_en_out(wr_en), .reg_rd_en_out(rd_en),
        .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata), .watchdog_enable_out(watchdog_enable),
        .strap_override_out(ov), .prog_select_out(psel));
    // ================================================================
    // Clock, 25 ns period
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end
    // ================================================================
    // Expected byte read back at an offset
    function automatic logic [7:0] exp_byte(input logic [7:0] x);
        case (x)
            RPF_OFF_RECOV_N:  return m_rn;
            RPF_OFF_RECOV_SM: return m_rsm;
            RPF_OFF_CPU_N:    return m_cn;
            RPF_OFF_CPU_EM:   return m_cem;
            RPF_OFF_FTEST:    return 8'h03;
            default:          return 8'h00;
        endcase
    endfunction
    // Expected selection outside recovery
    function automatic rpf_freq_cfg_t exp_norm();
        rpf_freq_cfg_t c;
        c.use_dividers = m_cem[7];
        c.div_n        = m_cn;
        c.div_m        = m_cem[6:0];
        c.ratio_sel    = ov ? psel : straps;
        return c;
    endfunction
    // ================================================================
    // Comparison, verdict and timeout pulse
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic pulse_timeout();
        @(posedge core_clk_in);
        tmo <= 1'b1;
        @(posedge core_clk_in);
        tmo <= 1'b0;
        #1;
    endtask
    // ================================================================
    // Watchdog; the whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge core_clk_in);
        miscompares++;
        complete_run();
    end
    // ================================================================
    // Main sequence
    initial begin
        seed = 85;
        miscompares = 0;
        n_checks = 0;
        rst_in = 1'b1;
        ce_in = 1'b1;
        tmo = 1'b0;
        rnd = $random(seed);
        straps = rnd[4:0];
        {m_rn, m_rsm, m_cn, m_cem} = 32'h0;
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        // Reset values, reserved bytes and one unmapped offset
        for (int i = 'h0B; i <= 'h12; i++) begin
            i_host.rd_byte(i[7:0], d);
            check(d, exp_byte(i[7:0]));
        end
        check(latched, straps);
        // Random writes: read back, load pulse and resulting selection
        for (int k = 0; k < 30; k++) begin
            rnd = $random(seed);
            a = 8'h0B + {5'h00, rnd[2:0]};
            i_host.set_bits(rnd[22], rnd[16], rnd[21:17]);
            i_host.wr_byte(a, rnd[15:8]);
            #1;
            check(load, a == RPF_OFF_CPU_EM);
            check(wstart, a == RPF_OFF_CPU_EM && watchdog_enable);
            case (a)
                RPF_OFF_RECOV_N:  m_rn = rnd[15:8];
                RPF_OFF_RECOV_SM: m_rsm = rnd[15:8];
                RPF_OFF_CPU_N:    m_cn = rnd[15:8];
                RPF_OFF_CPU_EM:   m_cem = rnd[15:8];
                default:          m_rn = m_rn;
            endcase
            repeat (2) @(posedge core_clk_in);
            #1;
            check(cfg, exp_norm());
            i_host.rd_byte(a, d);
            check(d, exp_byte(a));
        end
        // Clock enable low: a CPU M write is not taken, so no load and no change
        @(posedge core_clk_in);
        ce_in <= 1'b0;
        i_host.wr_byte(RPF_OFF_CPU_EM, ~m_cem);
        #1;
        check(load, 1'b0);
        @(posedge core_clk_in);
        ce_in <= 1'b1;
        i_host.rd_byte(RPF_OFF_CPU_EM, d);
        check(d, m_cem);
        // Recovery from each source, locked writes, unlock
        for (int s = 0; s < 2; s++) begin
            rnd = $random(seed);
            i_host.set_bits(1'b0, ov, psel);
            i_host.wr_byte(RPF_OFF_RECOV_N, rnd[7:0]);
            m_rn = rnd[7:0];
            m_rsm = {s[0], rnd[14:8]};
            i_host.wr_byte(RPF_OFF_RECOV_SM, m_rsm);
            pulse_timeout();
            check(locked, 1'b0);
            i_host.set_bits(1'b1, ov, psel);
            pulse_timeout();
            check(locked, 1'b1);
            check(load, 1'b1);
            check(cfg.use_dividers, s[0]);
            if (s == 1) begin
                check({cfg.div_n, cfg.div_m}, {m_rn, m_rsm[6:0]});
            end else begin
                check(cfg.ratio_sel, straps);
            end
            i_host.wr_byte(RPF_OFF_CPU_EM, ~m_cem);
            #1;
            check(load, 1'b0);
            i_host.rd_byte(RPF_OFF_CPU_EM, d);
            check(d, m_cem);
            pulse_timeout();
            check(load, 1'b0);
            i_host.set_bits(1'b0, ov, psel);
            repeat (3) @(posedge core_clk_in);
            #1;
            check(locked, 1'b0);
            check(cfg, exp_norm());
        end
        complete_run();
    end
endmodule
`default_nettype wire
